/* verilog/lsf_pkg.sv */
// Shared constants, register map and types for the line scan image formatter.
package lsf_pkg;

  // Pixel path geometry.
  localparam int PIX_W = 12;
  localparam int LANES = 8;
  localparam int HALF_LANES = 4;
  localparam int BUS_W = PIX_W * LANES;
  localparam int COL_W = 13;
  localparam int GRP_W = 10;
  localparam int GRP_SHIFT = 3;
  localparam int ALIGN_BITS = 4;
  localparam int ROW_W = 8;
  localparam int STAGE_W = 9;
  localparam int STAGE_STEP_DEF = 64;

  // Column window and frame limits.
  localparam logic [COL_W-1:0] SENSOR_COLS = 13'h19A0;
  localparam logic [COL_W-1:0] START_MAX = 13'h1990;
  localparam logic [COL_W-1:0] WIDTH_MIN = 13'h0010;
  localparam logic [COL_W-1:0] HEIGHT_MIN = 13'h0001;
  localparam logic [COL_W-1:0] HEIGHT_MAX = 13'h1000;
  localparam logic [PIX_W-1:0] PIX_MAX = 12'hFFF;
  localparam logic [3:0] LANES_FULL = 4'h8;
  localparam logic [3:0] LANES_HALF = 4'h4;

  // Register byte offsets.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_START = 8'h04;
  localparam logic [7:0] REG_WIDTH = 8'h08;
  localparam logic [7:0] REG_HEIGHT = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_FRAME = 8'h14;

  // Control register field positions.
  localparam int CTRL_STYLE_BIT = 0;
  localparam int CTRL_DIR_BIT = 1;
  localparam int CTRL_STAGE_LSB = 2;
  localparam int CTRL_HMERGE_BIT = 4;
  localparam int CTRL_VMERGE_BIT = 5;
  localparam int CTRL_DEPTH_LSB = 6;
  localparam int CTRL_ENABLE_BIT = 8;

  typedef enum logic {STYLE_TDI, STYLE_AREA} acq_style_t;
  typedef enum logic {DIR_FORWARD, DIR_REVERSE} scan_dir_t;
  typedef enum logic [1:0] {DEPTH_8 = 2'h0, DEPTH_10 = 2'h1, DEPTH_12 = 2'h2} pix_depth_t;

  // Reset values.
  localparam logic [1:0] STAGE_CODE_RST = 2'h0;
  localparam logic [COL_W-1:0] START_RST = 13'h0000;
  localparam logic [COL_W-1:0] HEIGHT_RST = 13'h0400;

endpackage : lsf_pkg

/* verilog/merge_reduce.sv */
// Combinational pixel merge (vertical, horizontal) and output depth reduction.
module merge_reduce (
  input wire logic [lsf_pkg::BUS_W-1:0] cur_i,
  input wire logic [lsf_pkg::BUS_W-1:0] prev_i,
  input wire logic vert_i,
  input wire logic horiz_i,
  input wire logic [1:0] depth_i,
  output logic [lsf_pkg::BUS_W-1:0] pix_o
);
  localparam int PW = lsf_pkg::PIX_W;

  logic [PW-1:0] vsum [lsf_pkg::LANES];
  logic [PW-1:0] hsum [lsf_pkg::LANES];

  // Sums saturate at full scale so the path stays 12 bits wide.
  genvar k;
  generate
    for (k = 0; k < lsf_pkg::LANES; k++) begin : g_lane
      logic [PW:0] vwide;
      logic [PW:0] hwide;
      logic [PW-1:0] full;
      assign vwide = {1'b0, cur_i[k*PW +: PW]} + (vert_i ? {1'b0, prev_i[k*PW +: PW]} : '0);
      assign vsum[k] = vwide[PW] ? lsf_pkg::PIX_MAX : vwide[PW-1:0];
      if (k < lsf_pkg::HALF_LANES) begin : g_pair
        assign hwide = {1'b0, vsum[2*k]} + {1'b0, vsum[2*k+1]};
        assign hsum[k] = horiz_i ? (hwide[PW] ? lsf_pkg::PIX_MAX : hwide[PW-1:0]) : vsum[k];
      end else begin : g_upper
        assign hwide = '0;
        assign hsum[k] = horiz_i ? '0 : vsum[k];
      end
      // Narrow depths keep the top bits and drop the low ones.
      assign full = hsum[k];
      always_comb begin
        case (depth_i)
          lsf_pkg::DEPTH_8: pix_o[k*PW +: PW] = {4'h0, full[PW-1:4]};
          lsf_pkg::DEPTH_10: pix_o[k*PW +: PW] = {2'h0, full[PW-1:2]};
          default: pix_o[k*PW +: PW] = full;
        endcase
      end
    end
  endgenerate

endmodule : merge_reduce

/* verilog/line_scan_image_formatter.sv */
// Line scan image formatter: window readout, merging, depth and virtual frames.
//
// Overview of operation
// - Two acquisition styles: area readout of rows, or integration line scan.
// - In line scan, stage code picks the integration stage count, steps of 32 or 64.
// - In area style, the stage count is the number of rows per area image.
// - Line scan charge shift direction follows a forward/reverse setting.
// - Area style with reverse direction reads rows bottom up, flipping the image.
// - Only columns from start to start plus width minus one are read and sent.
// - Start and width are multiples of 16; width at least 16.
// - Reset leaves the window at start zero and full sensor width.
// - Width writes of 16 to 6560 and start writes of 0 to 6544 are accepted.
// - Output lines are grouped into virtual frames of 1 to 4096 lines.
// - Horizontal merge by two sums adjacent pixel pairs; by one passes them.
// - Vertical merge by two sums adjacent line pairs into one line.
// - Pixels travel the internal path as 12-bit values.
// - Output depth is 8, 10 or 12 bits per pixel.
// - Eight pixels per clock keep 6560 columns above 18 kHz line rate.
//
// Implementation choices: the strobed register port and the register addresses.
module line_scan_image_formatter #(
  parameter int STAGE_STEP = lsf_pkg::STAGE_STEP_DEF
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  input wire logic line_trig_i,
  output logic sens_req_o,
  output logic [lsf_pkg::ROW_W-1:0] sens_row_o,
  output logic [lsf_pkg::GRP_W-1:0] sens_grp_o,
  input wire logic [lsf_pkg::BUS_W-1:0] sens_data_i,
  output logic area_style_o,
  output logic tdi_reverse_o,
  output logic [lsf_pkg::STAGE_W-1:0] tdi_stages_o,
  output logic out_valid_o,
  output logic [lsf_pkg::BUS_W-1:0] out_data_o,
  output logic [3:0] out_lanes_o,
  output logic out_sol_o,
  output logic out_eol_o,
  output logic out_sof_o,
  output logic out_eof_o
);
  localparam int CW = lsf_pkg::COL_W;
  localparam int GW = lsf_pkg::GRP_W;
  localparam int SW = lsf_pkg::STAGE_W;

  typedef enum {ST_IDLE, ST_READ} seq_state_t;

  logic style_reg, dir_reg, hmerge_reg, vmerge_reg, enable_reg;
  logic [1:0] stage_code_reg, depth_reg;
  logic [CW-1:0] start_reg, width_reg, height_reg;
  seq_state_t state_reg;
  logic [GW-1:0] grp_reg;
  logic vph_reg;
  logic [SW-1:0] line_idx_reg;
  logic s1_final_reg, s1_hold_reg, s1_first_reg, s1_last_reg, s1_vert_reg, s1_horiz_reg;
  logic [lsf_pkg::BUS_W-1:0] prev_reg;
  logic [CW-1:0] line_cnt_reg;
  logic [15:0] frame_cnt_reg;
  logic [31:0] rdata_reg;
  logic [lsf_pkg::BUS_W-1:0] merged;
  logic [SW-1:0] stages, area_lines, row_fwd;
  logic [CW:0] col_end;
  logic [GW-1:0] grp_first, grp_last;
  logic req_final, line_done, frame_last;
  logic [CW-1:0] wr_col;

  // Stage count derives from the code; area images are that many rows high.
  assign stages = SW'((32'(stage_code_reg) + 32'h1) * STAGE_STEP);
  assign area_lines = vmerge_reg ? (stages >> 1) : stages;
  assign tdi_stages_o = stages;
  assign area_style_o = style_reg;
  assign tdi_reverse_o = dir_reg;

  // Window bounds in groups of eight columns; a window past the sensor edge is cut there.
  assign col_end = {1'b0, start_reg} + {1'b0, width_reg};
  assign grp_first = GW'(start_reg >> lsf_pkg::GRP_SHIFT);
  always_comb begin
    if (col_end > {1'b0, lsf_pkg::SENSOR_COLS}) begin
      grp_last = GW'((lsf_pkg::SENSOR_COLS >> lsf_pkg::GRP_SHIFT) - 13'h0001);
    end else begin
      grp_last = GW'((col_end >> lsf_pkg::GRP_SHIFT) - 14'h0001);
    end
  end

  // Register writes; out-of-range values are dropped, alignment bits forced to zero.
  assign wr_col = {reg_wdata_i[CW-1:lsf_pkg::ALIGN_BITS], 4'h0};
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      style_reg <= lsf_pkg::STYLE_TDI;
      dir_reg <= lsf_pkg::DIR_FORWARD;
      stage_code_reg <= lsf_pkg::STAGE_CODE_RST;
      hmerge_reg <= 1'b0;
      vmerge_reg <= 1'b0;
      depth_reg <= lsf_pkg::DEPTH_8;
      enable_reg <= 1'b0;
      start_reg <= lsf_pkg::START_RST;
      width_reg <= lsf_pkg::SENSOR_COLS;
      height_reg <= lsf_pkg::HEIGHT_RST;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        lsf_pkg::REG_CTRL: begin
          style_reg <= reg_wdata_i[lsf_pkg::CTRL_STYLE_BIT];
          dir_reg <= reg_wdata_i[lsf_pkg::CTRL_DIR_BIT];
          stage_code_reg <= reg_wdata_i[lsf_pkg::CTRL_STAGE_LSB +: 2];
          hmerge_reg <= reg_wdata_i[lsf_pkg::CTRL_HMERGE_BIT];
          vmerge_reg <= reg_wdata_i[lsf_pkg::CTRL_VMERGE_BIT];
          enable_reg <= reg_wdata_i[lsf_pkg::CTRL_ENABLE_BIT];
          // The unused fourth depth code keeps the previous depth.
          if (reg_wdata_i[lsf_pkg::CTRL_DEPTH_LSB +: 2] != 2'h3) begin
            depth_reg <= reg_wdata_i[lsf_pkg::CTRL_DEPTH_LSB +: 2];
          end
        end
        lsf_pkg::REG_START: begin
          if (reg_wdata_i[31:CW] == '0 && wr_col <= lsf_pkg::START_MAX) begin
            start_reg <= wr_col;
          end
        end
        lsf_pkg::REG_WIDTH: begin
          if (reg_wdata_i[31:CW] == '0 && wr_col >= lsf_pkg::WIDTH_MIN
              && wr_col <= lsf_pkg::SENSOR_COLS) begin
            width_reg <= wr_col;
          end
        end
        lsf_pkg::REG_HEIGHT: begin
          if (reg_wdata_i[31:CW] == '0 && reg_wdata_i[CW-1:0] >= lsf_pkg::HEIGHT_MIN
              && reg_wdata_i[CW-1:0] <= lsf_pkg::HEIGHT_MAX) begin
            height_reg <= reg_wdata_i[CW-1:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Read data stands only in the cycle after the strobe; unmapped reads give zero.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || !reg_rd_i) begin
      rdata_reg <= '0;
    end else begin
      case (reg_addr_i)
        lsf_pkg::REG_CTRL: rdata_reg <= 32'({enable_reg, depth_reg, vmerge_reg, hmerge_reg,
                                              stage_code_reg, dir_reg, style_reg});
        lsf_pkg::REG_START: rdata_reg <= 32'(start_reg);
        lsf_pkg::REG_WIDTH: rdata_reg <= 32'(width_reg);
        lsf_pkg::REG_HEIGHT: rdata_reg <= 32'(height_reg);
        lsf_pkg::REG_STATUS: rdata_reg <= {16'(line_cnt_reg), 15'h0000, state_reg == ST_READ};
        lsf_pkg::REG_FRAME: rdata_reg <= 32'(frame_cnt_reg);
        default: rdata_reg <= '0;
      endcase
    end
  end
  assign reg_rdata_o = rdata_reg;

  // Readout sequencer: one group of eight columns per cycle, two rows per group when
  // merging vertically. Triggers during a readout are ignored rather than queued.
  assign line_done = (!vmerge_reg || vph_reg) && grp_reg == grp_last;
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_reg <= ST_IDLE;
      grp_reg <= '0;
      vph_reg <= 1'b0;
      line_idx_reg <= '0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (line_trig_i && enable_reg) begin
            state_reg <= ST_READ;
            grp_reg <= grp_first;
            vph_reg <= 1'b0;
            line_idx_reg <= '0;
          end
        end
        ST_READ: begin
          if (vmerge_reg && !vph_reg) begin
            vph_reg <= 1'b1;
          end else begin
            vph_reg <= 1'b0;
            if (!line_done) begin
              grp_reg <= grp_reg + 10'h001;
            end else if (style_reg == lsf_pkg::STYLE_AREA
                         && line_idx_reg != area_lines - 9'h001) begin
              line_idx_reg <= line_idx_reg + 9'h001;
              grp_reg <= grp_first;
            end else begin
              state_reg <= ST_IDLE;
            end
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Row address: area rows count up, or down from the last row when reversed.
  // Line scan reads the newest line (0) and, when merging, the one before it (1).
  assign row_fwd = (vmerge_reg ? (line_idx_reg << 1) : line_idx_reg) + SW'(vph_reg);
  always_comb begin
    if (style_reg == lsf_pkg::STYLE_AREA && dir_reg == lsf_pkg::DIR_REVERSE) begin
      sens_row_o = lsf_pkg::ROW_W'(stages - 9'h001 - row_fwd);
    end else if (style_reg == lsf_pkg::STYLE_AREA) begin
      sens_row_o = lsf_pkg::ROW_W'(row_fwd);
    end else begin
      sens_row_o = lsf_pkg::ROW_W'(vph_reg);
    end
  end
  assign sens_req_o = state_reg == ST_READ;
  assign sens_grp_o = grp_reg;
  assign req_final = sens_req_o && (!vmerge_reg || vph_reg);

  // Stage one tracks the request whose data return this cycle.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      s1_final_reg <= 1'b0;
      s1_hold_reg <= 1'b0;
      s1_first_reg <= 1'b0;
      s1_last_reg <= 1'b0;
      s1_vert_reg <= 1'b0;
      s1_horiz_reg <= 1'b0;
    end else begin
      s1_final_reg <= req_final;
      s1_hold_reg <= sens_req_o && vmerge_reg && !vph_reg;
      s1_first_reg <= grp_reg == grp_first;
      s1_last_reg <= line_done;
      s1_vert_reg <= vmerge_reg;
      s1_horiz_reg <= hmerge_reg;
    end
  end

  // First row of a vertical pair waits here for its partner.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      prev_reg <= '0;
    end else if (s1_hold_reg) begin
      prev_reg <= sens_data_i;
    end
  end

  merge_reduce u_merge (
    .cur_i(sens_data_i),
    .prev_i(prev_reg),
    .vert_i(s1_vert_reg),
    .horiz_i(s1_horiz_reg),
    .depth_i(depth_reg),
    .pix_o(merged)
  );

  // Output stage: data, lane count and line/frame markers leave together.
  assign frame_last = line_cnt_reg == height_reg - 13'h0001;
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      out_valid_o <= 1'b0;
      out_data_o <= '0;
      out_lanes_o <= '0;
      out_sol_o <= 1'b0;
      out_eol_o <= 1'b0;
      out_sof_o <= 1'b0;
      out_eof_o <= 1'b0;
    end else begin
      out_valid_o <= s1_final_reg;
      out_data_o <= s1_final_reg ? merged : '0;
      out_lanes_o <= s1_horiz_reg ? lsf_pkg::LANES_HALF : lsf_pkg::LANES_FULL;
      out_sol_o <= s1_final_reg && s1_first_reg;
      out_eol_o <= s1_final_reg && s1_last_reg;
      out_sof_o <= s1_final_reg && s1_first_reg && line_cnt_reg == '0;
      out_eof_o <= s1_final_reg && s1_last_reg && frame_last;
    end
  end

  // Virtual frame line counter; a height written mid-frame at or below the line count ends
  // the frame at the next line end because the compare is not exact.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      line_cnt_reg <= '0;
      frame_cnt_reg <= '0;
    end else if (s1_final_reg && s1_last_reg) begin
      if (line_cnt_reg >= height_reg - 13'h0001) begin
        line_cnt_reg <= '0;
        frame_cnt_reg <= frame_cnt_reg + 16'h0001;
      end else begin
        line_cnt_reg <= line_cnt_reg + 13'h0001;
      end
    end
  end

  // Checks.
  sequence s_pair_first;
    sens_req_o && vmerge_reg && !vph_reg;
  endsequence
  sequence s_pair_second(logic [GW-1:0] g);
    sens_req_o && vph_reg && sens_grp_o == g;
  endsequence
  // The group of the first row is remembered so the second row must reread it.
  property p_vert_pair;
    logic [GW-1:0] g;
    (s_pair_first, g = sens_grp_o) |=> s_pair_second(g);
  endproperty

  chk_window_low: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    sens_req_o |-> sens_grp_o >= grp_first) else $error("read left of window");
  chk_window_high: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    sens_req_o |-> sens_grp_o <= grp_last) else $error("read right of window");
  chk_reset_window: assert property (@(posedge clk_i)
    sys_rst_i |=> start_reg == '0 && width_reg == lsf_pkg::SENSOR_COLS)
    else $error("window not full after reset");
  chk_window_align: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    start_reg[3:0] == 4'h0 && width_reg[3:0] == 4'h0 && width_reg >= lsf_pkg::WIDTH_MIN)
    else $error("window misaligned");
  chk_area_flip: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $rose(sens_req_o) && style_reg && dir_reg |-> sens_row_o == lsf_pkg::ROW_W'(stages - 9'h001))
    else $error("reverse area image does not start at last row");
  chk_vert_pair: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    p_vert_pair) else $error("vertical pair broken");
  chk_req_to_out: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    req_final |-> ##2 out_valid_o) else $error("output not two cycles after read");
  chk_frame_wrap: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    out_eof_o |-> line_cnt_reg == '0 && $changed(frame_cnt_reg))
    else $error("frame end without count restart");
  chk_depth_top: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    out_valid_o && depth_reg == lsf_pkg::DEPTH_8 |-> out_data_o[11:8] == 4'h0)
    else $error("8-bit pixel wider than 8 bits");
  chk_merge_lanes: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    out_valid_o && out_lanes_o == lsf_pkg::LANES_HALF |-> out_data_o[95:48] == '0)
    else $error("upper lanes used with horizontal merge");

endmodule : line_scan_image_formatter

/* test/sensor_array_model.sv */
// Behavioural sensor array that answers each group read with eight pixels.
module sensor_array_model (
  input wire logic clk_i,
  input wire logic req_i,
  input wire logic [lsf_pkg::ROW_W-1:0] row_i,
  input wire logic [lsf_pkg::GRP_W-1:0] grp_i,
  output logic [lsf_pkg::BUS_W-1:0] data_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Each pixel carries its row and column, so a misplaced pixel shows up.
  // Between reads the lines invert every cycle, so stale data passes as fresh only after an even number of idle cycles.
  always @(posedge clk_i) begin
    if (req_i) begin
      for (int k = 0; k < 8; k++) begin
        data_o[12*k +: 12] <= {row_i[3:0], 8'(grp_i * 8 + k)};
      end
    end else begin
      data_o <= ~data_o;
    end
  end
endmodule : sensor_array_model

/* test/line_scan_image_formatter_tb_top.sv */
// Self-checking testbench for the line scan image formatter.
module line_scan_image_formatter_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int STEP = 32;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic line_trig_i = 1'b0;
  logic [31:0] reg_rdata_o;
  logic sens_req_o, area_style_o, tdi_reverse_o, out_valid_o;
  logic out_sol_o, out_eol_o, out_sof_o, out_eof_o;
  logic [lsf_pkg::ROW_W-1:0] sens_row_o;
  logic [lsf_pkg::GRP_W-1:0] sens_grp_o;
  logic [lsf_pkg::STAGE_W-1:0] tdi_stages_o;
  logic [lsf_pkg::BUS_W-1:0] sens_data_i, out_data_o;
  logic [3:0] out_lanes_o;
  int fail_count = 0;
  int n_tests = 0;
  // Expected-value state that follows the programmed configuration.
  int g_start, g_ngrp, g_height, g_fline, g_sh;
  bit g_area, g_rev, g_hm, g_vm;

  always #25 clk_i = ~clk_i;

  // A short stage step keeps each area image brief.
  line_scan_image_formatter #(.STAGE_STEP(STEP)) u_dut (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .line_trig_i(line_trig_i), .sens_req_o(sens_req_o),
    .sens_row_o(sens_row_o), .sens_grp_o(sens_grp_o), .sens_data_i(sens_data_i),
    .area_style_o(area_style_o), .tdi_reverse_o(tdi_reverse_o),
    .tdi_stages_o(tdi_stages_o), .out_valid_o(out_valid_o), .out_data_o(out_data_o),
    .out_lanes_o(out_lanes_o), .out_sol_o(out_sol_o), .out_eol_o(out_eol_o),
    .out_sof_o(out_sof_o), .out_eof_o(out_eof_o));

  sensor_array_model u_sensor (.clk_i(clk_i), .req_i(sens_req_o), .row_i(sens_row_o),
    .grp_i(sens_grp_o), .data_o(sens_data_i));

  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : stop_test

  // Compare tasks for register-sized and pixel-bus-sized results.
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_bus(input logic [95:0] got, input logic [95:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_bus

  // Register bus master: one-cycle strobes, read data in the following cycle.
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask : reg_wr

  task automatic reg_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1;
    chk_word(reg_rdata_o, exp);
  endtask : reg_chk

  task automatic wr_chk(input logic [7:0] a, input logic [31:0] d, input logic [31:0] exp);
    reg_wr(a, d);
    reg_chk(a, exp);
  endtask : wr_chk

  function automatic logic [31:0] ctrl_word(bit ar, bit rv, int cd, bit hm, bit vm, int dp);
    return 32'(ar) << lsf_pkg::CTRL_STYLE_BIT | 32'(rv) << lsf_pkg::CTRL_DIR_BIT
      | 32'(cd) << lsf_pkg::CTRL_STAGE_LSB | 32'(hm) << lsf_pkg::CTRL_HMERGE_BIT
      | 32'(vm) << lsf_pkg::CTRL_VMERGE_BIT | 32'(dp) << lsf_pkg::CTRL_DEPTH_LSB;
  endfunction : ctrl_word

  function automatic int pix(int row, int col);
    return (row % 16) * 256 + col % 256;
  endfunction : pix

  // Expected output group: merge sums, saturation, then keep the top bits.
  function automatic logic [95:0] exp_grp(int line, int g);
    logic [95:0] v;
    int row;
    int c;
    int s;
    v = '0;
    row = !g_area ? 0 : g_rev ? STEP - 1 - line : line;
    for (int j = 0; j < (g_hm ? 4 : 8); j++) begin
      c = g_start + 8 * g + (g_hm ? 2 * j : j);
      s = pix(row, c) + (g_vm ? pix(row + 1, c) : 0);
      if (g_hm) s += pix(row, c + 1) + (g_vm ? pix(row + 1, c + 1) : 0);
      v[12*j +: 12] = 12'((s > 4095 ? 4095 : s) >> g_sh);
    end
    return v;
  endfunction : exp_grp

  // Window and frame height; start plus width never passes the sensor edge.
  task automatic win(input int st, input int wd, input int ht);
    reg_wr(lsf_pkg::REG_START, 32'(st));
    reg_wr(lsf_pkg::REG_WIDTH, 32'(wd));
    reg_wr(lsf_pkg::REG_HEIGHT, 32'(ht));
    g_start = st;
    g_ngrp = wd / 8;
    g_height = ht;
    g_fline = 0;
  endtask : win

  task automatic setup(input bit ar, input bit rv, input bit hm, input bit vm, input int dp);
    g_area = ar;
    g_rev = rv;
    g_hm = hm;
    g_vm = vm;
    g_sh = (dp == 0) ? 4 : (dp == 1) ? 2 : 0;
    reg_wr(lsf_pkg::REG_CTRL, ctrl_word(ar, rv, 0, hm, vm, dp) | 32'h100);
  endtask : setup

  // One trigger, then every output group of every line is judged as it comes.
  task automatic grab(input int nlines);
    int n;
    @(posedge clk_i);
    line_trig_i <= 1'b1;
    @(posedge clk_i);
    line_trig_i <= 1'b0;
    for (int l = 0; l < nlines; l++) begin
      for (int g = 0; g < g_ngrp; g++) begin
        n = 0;
        do begin
          @(posedge clk_i);
          #1;
          n++;
        end while (out_valid_o !== 1'b1 && n < 300);
        if (out_valid_o !== 1'b1) begin
          fail_count++;
          stop_test();
        end
        chk_bus(out_data_o, exp_grp(l, g));
        chk_word({out_lanes_o, out_sol_o, out_eol_o, out_sof_o, out_eof_o},
          {g_hm ? 4'h4 : 4'h8, g == 0, g == g_ngrp - 1, g == 0 && g_fline == 0,
          g == g_ngrp - 1 && g_fline == g_height - 1});
        if (g > 0 && !g_vm) chk_word(n, 1);
      end
      g_fline = (g_fline + 1) % g_height;
    end
  endtask : grab

  task automatic reset_values;
    reg_chk(lsf_pkg::REG_START, 32'h0);
    reg_chk(lsf_pkg::REG_WIDTH, 32'h19A0);
    reg_chk(lsf_pkg::REG_HEIGHT, 32'h400);
    reg_chk(lsf_pkg::REG_CTRL, 32'h0);
    reg_chk(8'h20, 32'h0);
    chk_word(32'(tdi_stages_o), STEP);
  endtask : reset_values

  // Out-of-range writes are dropped; low four bits of start and width clear.
  task automatic window_limits;
    wr_chk(lsf_pkg::REG_CTRL, 32'hC0, 32'h0);
    wr_chk(lsf_pkg::REG_WIDTH, 32'h8, 32'h19A0);
    wr_chk(lsf_pkg::REG_WIDTH, 32'h19B0, 32'h19A0);
    wr_chk(lsf_pkg::REG_WIDTH, 32'h1F, 32'h10);
    wr_chk(lsf_pkg::REG_START, 32'h19A0, 32'h0);
    wr_chk(lsf_pkg::REG_START, 32'h1990, 32'h1990);
    wr_chk(lsf_pkg::REG_START, 32'h35, 32'h30);
    wr_chk(lsf_pkg::REG_HEIGHT, 32'h0, 32'h400);
    wr_chk(lsf_pkg::REG_HEIGHT, 32'h1001, 32'h400);
    wr_chk(lsf_pkg::REG_HEIGHT, 32'h1000, 32'h1000);
  endtask : window_limits

  // Every stage code with each style and direction level.
  task automatic style_settings;
    for (int c = 0; c < 4; c++) begin
      wr_chk(lsf_pkg::REG_CTRL, ctrl_word(c[0], c[1], c, 0, 0, 2),
        ctrl_word(c[0], c[1], c, 0, 0, 2));
      chk_word(32'(tdi_stages_o), (c + 1) * STEP);
      chk_word({area_style_o, tdi_reverse_o}, {c[0], c[1]});
    end
  endtask : style_settings

  task automatic depth_formats;
    win(48, 32, 1);
    for (int d = 0; d < 3; d++) begin
      setup(0, 0, 0, 0, d);
      grab(1);
    end
  endtask : depth_formats

  task automatic merge_modes;
    setup(0, 0, 1, 0, 2);
    grab(1);
    setup(0, 0, 0, 1, 2);
    grab(1);
    setup(0, 1, 1, 1, 0);
    grab(1);
  endtask : merge_modes

  // Two whole virtual frames of three lines each; six one-line frames came before.
  task automatic frame_grouping;
    win(48, 32, 3);
    setup(0, 0, 0, 0, 2);
    repeat (4) grab(1);
    reg_chk(lsf_pkg::REG_STATUS, 32'h0001_0000);
    repeat (2) grab(1);
    reg_chk(lsf_pkg::REG_FRAME, 32'h8);
  endtask : frame_grouping

  task automatic area_images;
    win(0, 16, STEP);
    setup(1, 0, 0, 0, 2);
    grab(STEP);
    setup(1, 1, 0, 0, 1);
    grab(STEP);
  endtask : area_images

  // Main sequence: three reset cycles, then each scenario in turn.
  initial begin
    repeat (3) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    reset_values();
    window_limits();
    style_settings();
    depth_formats();
    merge_modes();
    frame_grouping();
    area_images();
    stop_test();
  end
endmodule : line_scan_image_formatter_tb_top
